// [common/gpl_map.svh]
// Register offsets, field positions and reset values of the pin cell
`ifndef GPL_MAP_SVH
`define GPL_MAP_SVH

`define GPL_ADDR_W          12
`define GPL_CTRL_OFS        12'h000
`define GPL_STATUS_OFS      12'h004
`define GPL_DESER_OFS       12'h008

`define GPL_CTRL_RST        32'h0000_0000

`define GPL_MODE_LSB        0
`define GPL_MODE_MSB        2
`define GPL_RX_REG_BIT      3
`define GPL_RX_FALL_BIT     4
`define GPL_TX_REG_BIT      5
`define GPL_TX_FALL_BIT     6
`define GPL_OE_REG_BIT      7
`define GPL_OE_FALL_BIT     8
`define GPL_TX_INV_BIT      9
`define GPL_DOUBLE_EDGE_IO_RX_BIT     10
`define GPL_DOUBLE_EDGE_IO_TX_BIT     11
`define GPL_DOUBLE_EDGE_IO_LSB        12
`define GPL_DOUBLE_EDGE_IO_MSB        13
`define GPL_ALT_SEL_BIT     14
`define GPL_PULL_DN_BIT     15
`define GPL_SERDES_BIT      16
`define GPL_FULL_RATE_BIT   17
`define GPL_CFG_DONE_BIT    31
`define GPL_CTRL_MASK       32'h8003_ffff

`define GPL_ST_PAD_O_BIT    0
`define GPL_ST_PAD_OE_BIT   1
`define GPL_ST_RX_RISE_BIT  2
`define GPL_ST_RX_FALL_BIT  3
`define GPL_ST_PAD_IN_BIT   4
`define GPL_ST_SERDES_BIT   5
`define GPL_ST_PULL_UP_BIT  6
`define GPL_ST_PULL_DN_BIT  7

`define GPL_SYNC_W          3
`define GPL_DESER_RATIO     4

`endif

// [common/gpl_pkg.sv]
// Types shared by the pin cell modules
package gpl_pkg;

   typedef enum logic [2:0] {
      GPL_UNUSED,
      GPL_INPUT,
      GPL_OUTPUT,
      GPL_BIDIR,
      GPL_CLKOUT
   } gpl_mode_t;

   typedef enum logic [1:0] {
      GPL_DOUBLE_EDGE_IO_NORMAL,
      GPL_DOUBLE_EDGE_IO_RESYNC,
      GPL_DOUBLE_EDGE_IO_PIPE
   } gpl_double_edge_io_t;

endpackage

// [rtl/gpl_sync.sv]
// Two-flop synchroniser for inputs from outside the pclk domain
module gpl_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_q <= '0;
         sync_o <= '0;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end

endmodule // gpl_sync

// [rtl/gpl_edge_det.sv]
// Turns a synchronised clock level into rise and fall enable pulses
module gpl_edge_det (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic level_i,
   output logic      rise_o,
   output logic      fall_o
);

   logic last_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 1'b0;
      end else begin
         last_q <= level_i;
      end
   end

   assign rise_o = level_i & ~last_q;
   assign fall_o = ~level_i & last_q;

endmodule // gpl_edge_det

// [rtl/gpl_pin_cell.sv]
// General-purpose pin cell: capture, launch and drive-enable logic with APB
//
// Overview of operation
// R1: Cell holds capture, launch and drive-enable registers.
// R2: Input mode uses only the receive path, direct or registered.
// R3: Registered receive path captures on the chosen capture clock edge.
// R4: Bypass input goes to an alternate function and is never captured.
// R5: Double-edge input captures the pad on both capture clock edges.
// R6: Output mode uses only the transmit path, direct or registered.
// R7: Registered transmit path launches on the chosen launch clock edge.
// R8: In output and bidirectional modes the transmitted value may be inverted.
// R9: Double-edge output launches both core bits onto the one pad stream.
// R10: Bidirectional mode enables receive, transmit and drive-enable paths.
// R11: Capture clock times the receive register; launch clock the others.
// R12: Each register in bidirectional mode has its own edge select.
// R13: Receive and transmit paths choose registered or direct independently.
// R14: Clock-output mode drives the launch clock out to the pad.
// R15: Until configuration is done the pin sits in weak pull-up.
// R16: An unused pin after configuration is tristated with weak pull-up.
// R17: Software may pick weak pull-down for an unused pin instead.
// R18: One-to-four deserializer works only on a high-speed cell at full rate.
// R19: Double-edge bit 0 is rising-edge data, bit 1 falling-edge data.
// R20: Resync and pipeline modes hand both bits over on rising edge.
// R21: Resync input delays the falling-edge bit by half a cycle.
// R22: Capture, launch and enable registers start at zero, driver off.
// R23: With drive enable low the driver floats and capture continues.
module gpl_pin_cell #(
   parameter bit HIGH_SPEED_PIN_CELL = 1'b1
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_clock,
   input  wire logic        launch_clock,
   input  wire logic        core_tx_bit_rise,
   input  wire logic        core_tx_bit_fall,
   input  wire logic        core_oe,
   output logic             core_rx_bit_rise,
   output logic             core_rx_bit_fall,
   output logic             bypass_input,
   input  wire logic        pad_i,
   output logic             pad_o,
   output logic             pad_oe,
   output logic             pull_up_en,
   output logic             pull_dn_en
);

   import gpl_pkg::*;
   `include "gpl_map.svh"

   function automatic gpl_mode_t decode_mode(input logic [2:0] code);
      unique case (code)
         3'h1:    return GPL_INPUT;
         3'h2:    return GPL_OUTPUT;
         3'h3:    return GPL_BIDIR;
         3'h4:    return GPL_CLKOUT;
         default: return GPL_UNUSED;
      endcase
   endfunction

   function automatic gpl_double_edge_io_t decode_double_edge_io(input logic [1:0] code);
      unique case (code)
         2'h1:    return GPL_DOUBLE_EDGE_IO_RESYNC;
         2'h2:    return GPL_DOUBLE_EDGE_IO_PIPE;
         default: return GPL_DOUBLE_EDGE_IO_NORMAL;
      endcase
   endfunction

   logic [31:0] ctrl_q;
   logic [2:0]  sync_in;
   logic [2:0]  sync_out;
   logic        pad_s;
   logic        cap_s;
   logic        lau_s;
   logic        cap_rise;
   logic        cap_fall;
   logic        lau_rise;
   logic        lau_fall;
   gpl_mode_t   mode;
   gpl_double_edge_io_t   double_edge_io_mode;
   logic        cfg_done;
   logic        rx_on;
   logic        tx_on;
   logic        rx_edge;
   logic        tx_edge;
   logic        oe_edge;
   logic        serdes_ok;
   logic        cap_r_q;
   logic        cap_f_q;
   logic        tx_val_q;
   logic        tx_hold_q;
   logic        oe_val_q;
   logic [3:0]  des_sh_q;
   logic [1:0]  des_cnt_q;
   logic [3:0]  des_word_q;
   logic        apb_access;
   logic        apb_done;
   logic        addr_ok;
   logic [31:0] status_w;

   // Pad and the two fabric clocks come from outside pclk
   assign sync_in = {launch_clock, capture_clock, pad_i};

   gpl_sync #(
      .WIDTH (`GPL_SYNC_W)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .async_i (sync_in),
      .sync_o  (sync_out)
   );

   assign pad_s = sync_out[0];
   assign cap_s = sync_out[1];
   assign lau_s = sync_out[2];

   gpl_edge_det u_cap_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level_i (cap_s),
      .rise_o  (cap_rise),
      .fall_o  (cap_fall)
   );

   gpl_edge_det u_lau_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .level_i (lau_s),
      .rise_o  (lau_rise),
      .fall_o  (lau_fall)
   );

   // Configuration fields; before configuration the pin counts as unused
   assign cfg_done  = ctrl_q[`GPL_CFG_DONE_BIT];
   assign mode      = cfg_done ?
                      decode_mode(ctrl_q[`GPL_MODE_MSB:`GPL_MODE_LSB]) :
                      GPL_UNUSED;
   assign double_edge_io_mode = decode_double_edge_io(ctrl_q[`GPL_DOUBLE_EDGE_IO_MSB:`GPL_DOUBLE_EDGE_IO_LSB]);
   assign rx_on     = (mode == GPL_INPUT) || (mode == GPL_BIDIR); // R2 R10
   assign tx_on     = (mode == GPL_OUTPUT) || (mode == GPL_BIDIR); // R6 R10
   // Per-register edge choices, capture clock vs launch clock
   assign rx_edge = ctrl_q[`GPL_RX_FALL_BIT] ? cap_fall : cap_rise; // R3 R12
   assign tx_edge = ctrl_q[`GPL_TX_FALL_BIT] ? lau_fall : lau_rise; // R7 R12
   assign oe_edge = ctrl_q[`GPL_OE_FALL_BIT] ? lau_fall : lau_rise; // R11 R12
   assign serdes_ok = HIGH_SPEED_PIN_CELL & ctrl_q[`GPL_SERDES_BIT] &
                      ctrl_q[`GPL_FULL_RATE_BIT]; // R18

   // APB slave: one wait state, error on unmapped address
   assign apb_access = psel & penable;
   assign apb_done   = apb_access & pready;
   assign addr_ok    = (paddr == `GPL_CTRL_OFS) ||
                       (paddr == `GPL_STATUS_OFS) ||
                       (paddr == `GPL_DESER_OFS);

   always_comb begin
      status_w = 32'h0000_0000;
      status_w[`GPL_ST_PAD_O_BIT]   = pad_o;
      status_w[`GPL_ST_PAD_OE_BIT]  = pad_oe;
      status_w[`GPL_ST_RX_RISE_BIT] = core_rx_bit_rise;
      status_w[`GPL_ST_RX_FALL_BIT] = core_rx_bit_fall;
      status_w[`GPL_ST_PAD_IN_BIT]  = pad_s; // R23
      status_w[`GPL_ST_SERDES_BIT]  = serdes_ok;
      status_w[`GPL_ST_PULL_UP_BIT] = pull_up_en;
      status_w[`GPL_ST_PULL_DN_BIT] = pull_dn_en;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apb_access & ~pready;
         pslverr <= apb_access & ~pready & ~addr_ok;
         prdata  <= 32'h0000_0000;
         if (apb_access && !pready && !pwrite) begin
            unique case (paddr)
               `GPL_CTRL_OFS:   prdata <= ctrl_q;
               `GPL_STATUS_OFS: prdata <= status_w;
               `GPL_DESER_OFS:  prdata <= {28'h000_0000, des_word_q};
               default:         prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `GPL_CTRL_RST; // R15
      end else if (apb_done && pwrite && paddr == `GPL_CTRL_OFS) begin
         ctrl_q <= pwdata & `GPL_CTRL_MASK;
      end
   end

   // Double-edge capture holders, one per capture clock edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_r_q <= 1'b0; // R22
         cap_f_q <= 1'b0;
      end else begin
         if (cap_rise) begin
            cap_r_q <= pad_s; // R5
         end
         if (cap_fall) begin
            cap_f_q <= pad_s; // R5
         end
      end
   end

   // Receive path toward the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_rx_bit_rise <= 1'b0; // R22
         core_rx_bit_fall <= 1'b0;
      end else if (!rx_on) begin
         core_rx_bit_rise <= 1'b0; // R6
         core_rx_bit_fall <= 1'b0;
      end else if (ctrl_q[`GPL_DOUBLE_EDGE_IO_RX_BIT]) begin
         unique case (double_edge_io_mode)
            GPL_DOUBLE_EDGE_IO_NORMAL: begin
               if (cap_rise) begin
                  core_rx_bit_rise <= pad_s; // R19
               end
               if (cap_fall) begin
                  core_rx_bit_fall <= pad_s; // R19
               end
            end
            GPL_DOUBLE_EDGE_IO_RESYNC: begin
               if (cap_rise) begin
                  core_rx_bit_rise <= pad_s; // R20
                  core_rx_bit_fall <= cap_f_q; // R21
               end
            end
            GPL_DOUBLE_EDGE_IO_PIPE: begin
               if (cap_rise) begin
                  core_rx_bit_rise <= cap_r_q; // R20
                  core_rx_bit_fall <= cap_f_q; // R20
               end
            end
         endcase
      end else if (ctrl_q[`GPL_RX_REG_BIT]) begin
         if (rx_edge) begin
            core_rx_bit_rise <= pad_s; // R1 R3 R13
         end
         core_rx_bit_fall <= 1'b0;
      end else begin
         core_rx_bit_rise <= pad_s; // R2 R13
         core_rx_bit_fall <= 1'b0;
      end
   end

   // Alternate path: synchronised pad only, no capture register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bypass_input <= 1'b0;
      end else begin
         bypass_input <= ctrl_q[`GPL_ALT_SEL_BIT] &
                         (mode == GPL_INPUT) & pad_s; // R4
      end
   end

   // Transmit launch register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_val_q  <= 1'b0; // R22
         tx_hold_q <= 1'b0;
      end else if (!tx_on) begin
         tx_val_q  <= 1'b0; // R2
         tx_hold_q <= 1'b0;
      end else if (ctrl_q[`GPL_DOUBLE_EDGE_IO_TX_BIT]) begin
         if (double_edge_io_mode == GPL_DOUBLE_EDGE_IO_NORMAL) begin
            if (lau_rise) begin
               tx_val_q <= core_tx_bit_rise; // R9 R19
            end
            if (lau_fall) begin
               tx_val_q <= core_tx_bit_fall; // R9 R19
            end
         end else begin
            if (lau_rise) begin
               tx_val_q  <= core_tx_bit_rise; // R20
               tx_hold_q <= core_tx_bit_fall; // R20
            end
            if (lau_fall) begin
               tx_val_q <= tx_hold_q; // R9
            end
         end
      end else if (ctrl_q[`GPL_TX_REG_BIT]) begin
         if (tx_edge) begin
            tx_val_q <= core_tx_bit_rise; // R1 R7 R13
         end
      end else begin
         tx_val_q <= core_tx_bit_rise; // R6 R13
      end
   end

   // Drive-enable register, used in bidirectional mode only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oe_val_q <= 1'b0; // R22
      end else if (mode != GPL_BIDIR) begin
         oe_val_q <= 1'b0;
      end else if (ctrl_q[`GPL_OE_REG_BIT]) begin
         if (oe_edge) begin
            oe_val_q <= core_oe; // R1 R10 R11
         end
      end else begin
         oe_val_q <= core_oe; // R10
      end
   end

   // Pad drive, enable and pulls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_o      <= 1'b0;
         pad_oe     <= 1'b0; // R22
         pull_up_en <= 1'b1; // R15
         pull_dn_en <= 1'b0;
      end else begin
         unique case (mode)
            GPL_CLKOUT: begin
               pad_o  <= lau_s; // R14
               pad_oe <= 1'b1;
            end
            GPL_OUTPUT: begin
               pad_o  <= tx_val_q ^ ctrl_q[`GPL_TX_INV_BIT]; // R8
               pad_oe <= 1'b1;
            end
            GPL_BIDIR: begin
               pad_o  <= tx_val_q ^ ctrl_q[`GPL_TX_INV_BIT]; // R8
               pad_oe <= oe_val_q; // R23
            end
            default: begin
               pad_o  <= 1'b0;
               pad_oe <= 1'b0; // R16
            end
         endcase
         pull_up_en <= !cfg_done ||
                       (mode == GPL_UNUSED &&
                        !ctrl_q[`GPL_PULL_DN_BIT]); // R15 R16
         pull_dn_en <= cfg_done && mode == GPL_UNUSED &&
                       ctrl_q[`GPL_PULL_DN_BIT]; // R17
      end
   end

   // One-to-four deserializer on the receive capture edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         des_sh_q   <= 4'h0;
         des_cnt_q  <= 2'h0;
         des_word_q <= 4'h0;
      end else if (!serdes_ok || !rx_on) begin
         des_cnt_q <= 2'h0; // R18
      end else if (rx_edge) begin
         des_sh_q  <= {des_sh_q[2:0], pad_s}; // R18
         des_cnt_q <= des_cnt_q + 2'h1;
         if (des_cnt_q == 2'h3) begin
            des_word_q <= {des_sh_q[2:0], pad_s};
         end
      end
   end

endmodule // gpl_pin_cell

// [verification/gpl_pin_cell_properties.sv]
// Concurrent checks on the pin cell ports, bound into every instance
`include "gpl_map.svh"
module gpl_pin_cell_properties (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        launch_clock,
   input wire logic        core_tx_bit_rise,
   input wire logic        core_rx_bit_rise,
   input wire logic        bypass_input,
   input wire logic        pad_i,
   input wire logic        pad_o,
   input wire logic        pad_oe,
   input wire logic        pull_up_en,
   input wire logic        pull_dn_en
);
   import gpl_pkg::*;
   logic [31:0] ctl_q;
   logic [3:0]  age_q;
   logic        wr_ctl;
   logic        st;
   logic        dn;
   logic [2:0]  md;
   assign wr_ctl = psel && penable && pready && pwrite
                   && paddr == `GPL_CTRL_OFS;
   // Pull, drive and path checks wait until the pin pipeline has settled after a CTRL write
   assign st = age_q[3];
   assign dn = ctl_q[31];
   assign md = ctl_q[2:0];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ctl_q <= 32'h0;
      else if (wr_ctl) ctl_q <= pwdata;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) age_q <= 4'h0;
      else if (wr_ctl) age_q <= 4'h0;
      else if (age_q != 4'hf) age_q <= age_q + 4'h1;
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_wait: assert property (p_wait)
      else $error("ready not given after one wait state");
   property p_err;
      pslverr |-> pready;
   endproperty
   a_err: assert property (p_err) else $error("error without ready");
   property p_rst;
      disable iff (1'b0) !presetn |-> !pad_oe && !pad_o && pull_up_en;
   endproperty
   a_rst: assert property (p_rst)
      else $error("pin not idle in reset");
   property p_unconf;
      st && !dn |-> pull_up_en && !pull_dn_en && !pad_oe;
   endproperty
   a_unconf: assert property (p_unconf)
      else $error("unconfigured pin not pulled up");
   property p_unused;
      st && dn && md == 3'h0 |-> !pad_oe && pull_dn_en == ctl_q[15]
         && pull_up_en == !ctl_q[15];
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused pin pull or drive wrong");
   property p_rx;
      st && dn && md == 3'h1 && !ctl_q[3] && !ctl_q[10]
         |-> core_rx_bit_rise == $past(pad_i, 3) && !pad_oe;
   endproperty
   a_rx: assert property (p_rx)
      else $error("direct receive path wrong");
   property p_byp;
      st && !(dn && md == 3'h1 && ctl_q[14]) |-> !bypass_input;
   endproperty
   a_byp: assert property (p_byp)
      else $error("bypass input active when not selected");
   property p_tx;
      st && dn && md == 3'h2 && !ctl_q[5] && !ctl_q[11] |-> pad_oe
         && pad_o == ($past(core_tx_bit_rise, 2) ^ ctl_q[9]);
   endproperty
   a_tx: assert property (p_tx)
      else $error("direct transmit path wrong");
   property p_ck;
      st && dn && md == 3'h4 |-> pad_oe && pad_o == $past(launch_clock, 3);
   endproperty
   a_ck: assert property (p_ck)
      else $error("clock output path wrong");
endmodule // gpl_pin_cell_properties

bind gpl_pin_cell gpl_pin_cell_properties u_chk (.*);

// [verification/gpl_pad_model.sv]
// Board side of the pad: external driver, weak pulls, floating line
module gpl_pad_model (
   input  wire logic pclk,
   input  wire logic pad_o,
   input  wire logic pad_oe,
   input  wire logic pull_up_en,
   input  wire logic pull_dn_en,
   input  wire logic drv_en,
   input  wire logic drv_val,
   output logic      pad_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_q = 1'b0;
   // A floating line changes every cycle rather than keep a stale level
   always_ff @(posedge pclk) last_q <= pad_i;
   always_comb begin
      if (pad_oe) pad_i = pad_o;
      else if (drv_en) pad_i = drv_val;
      else if (pull_up_en) pad_i = 1'b1;
      else if (pull_dn_en) pad_i = 1'b0;
      else pad_i = ~last_q;
   end
endmodule // gpl_pad_model

// [verification/gpl_pin_cell_tb_top.sv]
// Self-checking bench for the pin cell
`include "gpl_map.svh"
module gpl_pin_cell_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import gpl_pkg::*;
   localparam logic [31:0] M_IN = 32'(GPL_INPUT), M_OUT = 32'(GPL_OUTPUT),
      M_BI = 32'(GPL_BIDIR), M_CK = 32'(GPL_CLKOUT), RXR = 32'h8,
      RXF = 32'h10, TXR = 32'h20, TXF = 32'h40, OER = 32'h80,
      INV = 32'h200, DRX = 32'h400, DTX = 32'h800, RSY = 32'h1000,
      BYPASS_INPUT = 32'h4000, PDN = 32'h8000, PIP = 32'h2000, SER = 32'h1_0000,
      FRT = 32'h2_0000;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        capture_clock, launch_clock, core_oe, pad_i, pad_o, pad_oe;
   logic        core_tx_bit_rise, core_tx_bit_fall, bypass_input;
   logic        core_rx_bit_rise, core_rx_bit_fall, pull_up_en, pull_dn_en;
   logic        drv_en, drv_val;
   int          num_errors, checked;

   gpl_pin_cell u_dut (.*);
   gpl_pad_model u_pad (.*);

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic results();
      $display("errors %0d, checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) begin
         num_errors++;
         results();
      end
   endtask

   task automatic cfg(input logic [31:0] v);
      apb(1'b1, `GPL_CTRL_OFS, v | 32'h8000_0000);
      repeat (8) @(posedge pclk);
   endtask

   task automatic tog(input logic l, input logic v);
      if (l) launch_clock <= v;
      else capture_clock <= v;
      repeat (8) @(posedge pclk);
   endtask

   task automatic pad(input logic v);
      drv_en <= 1'b1;
      drv_val <= v;
      repeat (8) @(posedge pclk);
   endtask

   task automatic t_reset();
      chk({pad_oe, pad_o, pull_up_en, core_rx_bit_rise}, 4'h2);
      apb(1'b0, `GPL_CTRL_OFS, 32'h0);
      chk(rd, `GPL_CTRL_RST);
      apb(1'b0, 12'h00c, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, `GPL_CTRL_OFS, 32'hffff_ffff);
      apb(1'b0, `GPL_CTRL_OFS, 32'h0);
      chk(rd, `GPL_CTRL_MASK);
      apb(1'b1, `GPL_CTRL_OFS, M_OUT);
      repeat (8) @(posedge pclk);
      chk({pad_oe, pull_up_en}, 2'b01);
   endtask

   task automatic t_unused();
      cfg(32'h0);
      chk({pad_oe, pull_up_en, pull_dn_en}, 3'b010);
      cfg(PDN);
      chk({pad_oe, pull_up_en, pull_dn_en}, 3'b001);
   endtask

   task automatic t_rx();
      cfg(M_IN);
      pad(1'b1);
      chk({core_rx_bit_rise, pad_oe, bypass_input}, 3'b100);
      cfg(M_IN | RXR);
      tog(1'b0, 1'b1);
      chk(core_rx_bit_rise, 1'b1);
      pad(1'b0);
      chk(core_rx_bit_rise, 1'b1);
      tog(1'b0, 1'b0);
      chk(core_rx_bit_rise, 1'b1);
      cfg(M_IN | RXR | RXF);
      tog(1'b0, 1'b1);
      chk(core_rx_bit_rise, 1'b1);
      tog(1'b0, 1'b0);
      chk(core_rx_bit_rise, 1'b0);
      cfg(M_IN | BYPASS_INPUT);
      pad(1'b1);
      chk(bypass_input, 1'b1);
      pad(1'b0);
      chk(bypass_input, 1'b0);
   endtask

   task automatic t_double_edge_io_in();
      cfg(M_IN | RXR | DRX);
      pad(1'b1);
      tog(1'b0, 1'b1);
      pad(1'b0);
      tog(1'b0, 1'b0);
      chk({core_rx_bit_rise, core_rx_bit_fall}, 2'b10);
      cfg(M_IN | RXR | DRX | RSY);
      pad(1'b1);
      tog(1'b0, 1'b1);
      tog(1'b0, 1'b0);
      chk({core_rx_bit_rise, core_rx_bit_fall}, 2'b10);
      pad(1'b0);
      tog(1'b0, 1'b1);
      chk({core_rx_bit_rise, core_rx_bit_fall}, 2'b01);
      cfg(M_IN | RXR | DRX | PIP);
      pad(1'b1);
      tog(1'b0, 1'b0);
      tog(1'b0, 1'b1);
      chk({core_rx_bit_rise, core_rx_bit_fall}, 2'b01);
      tog(1'b0, 1'b0);
      tog(1'b0, 1'b1);
      chk({core_rx_bit_rise, core_rx_bit_fall}, 2'b11);
   endtask

   task automatic t_deser();
      logic [3:0] w;
      w = 4'hb;
      cfg(M_IN | RXR | SER | FRT);
      for (int i = 3; i >= 0; i--) begin
         pad(w[i]);
         tog(1'b0, 1'b0);
         tog(1'b0, 1'b1);
      end
      apb(1'b0, `GPL_DESER_OFS, 32'h0);
      chk(rd, {28'h000_0000, w});
      apb(1'b0, `GPL_STATUS_OFS, 32'h0);
      chk(rd, 32'h0000_0034);
   endtask

   task automatic t_tx();
      core_tx_bit_rise <= 1'b1;
      cfg(M_OUT);
      chk({pad_oe, pad_o, pull_up_en, pull_dn_en}, 4'hc);
      cfg(M_OUT | INV);
      chk(pad_o, 1'b0);
      cfg(M_OUT | TXR | TXF);
      tog(1'b1, 1'b1);
      tog(1'b1, 1'b0);
      chk(pad_o, 1'b1);
      core_tx_bit_rise <= 1'b0;
      tog(1'b1, 1'b1);
      chk(pad_o, 1'b1);
      tog(1'b1, 1'b0);
      chk(pad_o, 1'b0);
      core_tx_bit_rise <= 1'b1;
      cfg(M_OUT | TXR | DTX);
      tog(1'b1, 1'b1);
      chk(pad_o, 1'b1);
      tog(1'b1, 1'b0);
      chk(pad_o, 1'b0);
   endtask

   task automatic t_bidir();
      core_oe <= 1'b0;
      cfg(M_BI | TXR | OER);
      tog(1'b1, 1'b1);
      chk(pad_oe, 1'b0);
      pad(1'b1);
      chk(core_rx_bit_rise, 1'b1);
      core_oe <= 1'b1;
      drv_en <= 1'b0;
      tog(1'b1, 1'b0);
      chk(pad_oe, 1'b0);
      tog(1'b1, 1'b1);
      chk({pad_oe, pad_o, core_rx_bit_rise}, 3'b111);
      cfg(M_CK);
      tog(1'b1, 1'b0);
      chk({pad_oe, pad_o}, 2'b10);
      tog(1'b1, 1'b1);
      chk({pad_oe, pad_o}, 2'b11);
   endtask

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      capture_clock = 1'b0;
      launch_clock = 1'b0;
      core_tx_bit_rise = 1'b0;
      core_tx_bit_fall = 1'b0;
      core_oe = 1'b0;
      drv_en = 1'b0;
      drv_val = 1'b0;
      num_errors = 0;
      checked = 0;
      presetn = 1'b1;
      #1 presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_unused();
      t_rx();
      t_double_edge_io_in();
      t_deser();
      t_tx();
      t_bidir();
      results();
   end
endmodule // gpl_pin_cell_tb_top
